/* design/serial_slave_consts.svh */
`ifndef SERIAL_SLAVE_CONSTS_SVH
`define SERIAL_SLAVE_CONSTS_SVH

// Byte count and limit width
`define CNT_W 10
// Buffer address width
`define ADDR_W 16
// Last bit index inside a byte
`define LAST_BIT 3'h7
// Reset values
`define CNT_RST 10'h000
`define ADDR_RST 16'h0000
`define BYTE_RST 8'h00

`endif

/* design/serial_slave_pkg.sv */
`include "serial_slave_consts.svh"

package serial_slave_pkg;

    // Semaphore holder
    typedef enum logic [1:0] {
        OWN_FREE = 2'h0,
        OWN_CPU = 2'h1,
        OWN_SLAVE = 2'h2
    } sem_owner_t;

    // Transaction progress
    typedef enum logic [1:0] {
        X_IDLE = 2'h0,
        X_GRANT = 2'h1,
        X_IGNORE = 2'h2,
        X_FINISH = 2'h3
    } xfer_state_t;

    // Serial format settings
    typedef struct packed {
        logic cpol;
        logic cpha;
        logic lsb_first;
    } spi_cfg_t;

    // Receive buffer write strobe
    typedef struct packed {
        logic en;
        logic [`ADDR_W-1:0] addr;
        logic [7:0] data;
    } dma_wr_t;

endpackage : serial_slave_pkg

/* design/serial_slave_unit.sv */
// Contract
// - All four clock modes via polarity, phase
// - Shared settings persist across peer disable
// - Bytes beyond transmit limit send pad
// - Done event only after buffer access ends
// - CPU claims, waits grant, then hands back
// - Handback without CPU ownership does nothing
// - Ownership never blocks CPU buffer access
// - Enable gives CPU ownership, no event
// - Claim while CPU owns grants immediately
// - Lost semaphore ignores whole transaction
// - Simultaneous request goes to CPU
// - Granted: store MOSI, send transmit bytes
// - Granted end releases semaphore, raises done
// - Free semaphore regrants with same pointers
// - Shortcut passes semaphore to CPU after done
// - Claim during slave ownership is deferred
// - Shortcut plus claim serves one request
// - Receive overflow flags and drops bytes
// - Excess transmit sets flag, sends pad
// - Byte counts updated at granted end
// - Receive buffer full raises event
// - MISO released while not selected
// - Bit order zero MSB, one LSB
// - Phase picks sampling and shifting edge
`timescale 1ns/100ps
`default_nettype none
`include "serial_slave_consts.svh"

module serial_slave_unit
    import serial_slave_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Configuration
    input wire logic enable,
    input wire spi_cfg_t cfg,
    input wire logic [7:0] tx_pad_char,
    input wire logic [7:0] ignored_fill_char,
    input wire logic [`CNT_W-1:0] rx_byte_limit,
    input wire logic [`CNT_W-1:0] tx_byte_limit,
    input wire logic [`ADDR_W-1:0] rx_buffer_pointer,
    input wire logic [`ADDR_W-1:0] tx_buffer_pointer,
    input wire logic short_done_claim,
    // Tasks
    input wire logic claim_task,
    input wire logic handback_task,
    // Serial pins
    input wire logic csn_pin,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    output logic miso_out,
    output logic miso_oe,
    // Buffer access
    output dma_wr_t rx_wr,
    output logic tx_rd_en,
    output logic [`ADDR_W-1:0] tx_rd_addr,
    input wire logic [7:0] tx_rd_data,
    // Events
    output logic acquired_event,
    output logic done_event,
    output logic rx_buffer_full_event,
    // Status
    output sem_owner_t sem_owner,
    output logic rx_overflow_flag,
    output logic tx_excess_flag,
    output logic [`CNT_W-1:0] rx_bytes_done,
    output logic [`CNT_W-1:0] tx_bytes_done
);

    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic sck_prev_reg;
    logic csn_prev_reg;
    xfer_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_sr_reg;
    logic [7:0] tx_byte_reg;
    logic cur_pad_reg;
    logic [`CNT_W-1:0] rx_cnt_reg;
    logic [`CNT_W-1:0] tx_cnt_reg;
    logic claim_pend_reg;
    sem_owner_t owner_next;
    logic acq_next;
    logic pend_next;
    logic grant_now;

    // Two-stage synchronisers for csn, sck, mosi
    always_ff @(posedge ref_clk) begin
        pin_meta_reg <= {csn_pin, sck_pin, mosi_pin};
        pin_sync_reg <= pin_meta_reg;
    end

    wire csn_s = pin_sync_reg[2];
    wire sck_s = pin_sync_reg[1];
    wire mosi_s = pin_sync_reg[0];

    // Edge history of the synchronised sck and csn pins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sck_prev_reg <= 1'b0;
            csn_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_s;
            csn_prev_reg <= csn_s;
        end
    end

    wire sck_toggle = sck_s != sck_prev_reg;
    wire lead_edge = sck_toggle & (sck_prev_reg == cfg.cpol);
    wire trail_edge = sck_toggle & (sck_s == cfg.cpol);
    wire cs_fall = enable & csn_prev_reg & ~csn_s;
    wire cs_rise = ~csn_prev_reg & csn_s;
    wire granted = state_reg == X_GRANT;
    wire active = granted | (state_reg == X_IGNORE);
    wire sample_edge = active & (cfg.cpha ? trail_edge : lead_edge);
    wire byte_done = sample_edge & (bit_cnt_reg == `LAST_BIT);
    wire [7:0] rx_byte = cfg.lsb_first ? {mosi_s, rx_sr_reg[7:1]}
                                       : {rx_sr_reg[6:0], mosi_s};
    wire [2:0] tx_idx = cfg.lsb_first ? bit_cnt_reg
                                      : `LAST_BIT - bit_cnt_reg;
    wire start_any = (state_reg == X_IDLE) & cs_fall;
    wire grant_path = start_any ? grant_now : granted;
    wire load_pt = start_any | byte_done;
    wire [`CNT_W-1:0] tx_cnt_next = start_any ? `CNT_RST
        : tx_cnt_reg + `CNT_W'({9'h000, ~cur_pad_reg});
    wire fetch = load_pt & grant_path & (tx_cnt_next < tx_byte_limit);
    wire rx_room = rx_cnt_reg < rx_byte_limit;
    wire rx_store = byte_done & granted & rx_room;
    // done waits for the write strobe to drain
    wire end_now = (state_reg == X_FINISH) & ~rx_wr.en;

    // Semaphore arbitration
    always_comb begin
        owner_next = sem_owner;
        acq_next = 1'b0;
        pend_next = claim_pend_reg;
        grant_now = 1'b0;
        if (!enable) begin
            // enable hands CPU the semaphore silently
            owner_next = OWN_CPU;
            pend_next = 1'b0;
        end else begin
            unique case (sem_owner)
                OWN_CPU: begin
                    if (claim_task) begin
                        acq_next = 1'b1;
                    end else if (handback_task) begin
                        owner_next = OWN_FREE;
                    end
                end
                OWN_FREE: begin
                    if (claim_task) begin
                        owner_next = OWN_CPU;
                        acq_next = 1'b1;
                    end else if (cs_fall) begin
                        owner_next = OWN_SLAVE;
                        grant_now = 1'b1;
                    end
                end
                OWN_SLAVE: begin
                    if (claim_task) begin
                        pend_next = 1'b1;
                    end
                    if (end_now) begin
                        pend_next = 1'b0;
                        if (short_done_claim | claim_pend_reg
                            | claim_task) begin
                            owner_next = OWN_CPU;
                            acq_next = 1'b1;
                        end else begin
                            owner_next = OWN_FREE;
                        end
                    end
                end
                default: begin
                    owner_next = OWN_CPU;
                end
            endcase
        end
    end

    // handback ignored unless CPU holds it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sem_owner <= OWN_CPU;
            claim_pend_reg <= 1'b0;
            acquired_event <= 1'b0;
        end else begin
            sem_owner <= owner_next;
            claim_pend_reg <= pend_next;
            acquired_event <= acq_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || !enable) begin
            state_reg <= X_IDLE;
        end else begin
            unique case (state_reg)
                X_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= grant_now ? X_GRANT : X_IGNORE;
                    end
                end
                X_GRANT: begin
                    if (cs_rise) begin
                        state_reg <= X_FINISH;
                    end
                end
                X_IGNORE: begin
                    if (cs_rise) begin
                        state_reg <= X_IDLE;
                    end
                end
                X_FINISH: begin
                    if (end_now) begin
                        state_reg <= X_IDLE;
                    end
                end
            endcase
        end
    end

    // Bit counter and receive shifter
    always_ff @(posedge ref_clk) begin
        if (reset || start_any) begin
            bit_cnt_reg <= 3'h0;
            rx_sr_reg <= `BYTE_RST;
        end else if (sample_edge) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_sr_reg <= rx_byte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_rd_en <= 1'b0;
            tx_rd_addr <= `ADDR_RST;
            tx_byte_reg <= `BYTE_RST;
            cur_pad_reg <= 1'b0;
        end else begin
            tx_rd_en <= fetch;
            if (fetch) begin
                tx_rd_addr <= tx_buffer_pointer + `ADDR_W'(tx_cnt_next);
            end
            if (tx_rd_en) begin
                tx_byte_reg <= tx_rd_data;
            // pad beyond limit, fill if ignored
            end else if (load_pt && !fetch) begin
                tx_byte_reg <= grant_path ? tx_pad_char
                                          : ignored_fill_char;
            end
            if (load_pt) begin
                cur_pad_reg <= grant_path & ~fetch;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_out <= tx_byte_reg[tx_idx];
            miso_oe <= enable & ~csn_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_wr <= '0;
            rx_cnt_reg <= `CNT_RST;
            tx_cnt_reg <= `CNT_RST;
            rx_overflow_flag <= 1'b0;
            tx_excess_flag <= 1'b0;
            rx_buffer_full_event <= 1'b0;
        end else begin
            rx_wr.en <= rx_store;
            rx_wr.addr <= rx_buffer_pointer + `ADDR_W'(rx_cnt_reg);
            rx_wr.data <= rx_byte;
            rx_buffer_full_event <= rx_store
                & (rx_cnt_reg + `CNT_W'(1) == rx_byte_limit);
            if (start_any && grant_now) begin
                rx_cnt_reg <= `CNT_RST;
                tx_cnt_reg <= `CNT_RST;
                rx_overflow_flag <= 1'b0;
                tx_excess_flag <= 1'b0;
            end else if (byte_done && granted) begin
                tx_cnt_reg <= tx_cnt_next;
                if (rx_room) begin
                    rx_cnt_reg <= rx_cnt_reg + `CNT_W'(1);
                end else begin
                    rx_overflow_flag <= 1'b1;
                end
                if (cur_pad_reg) begin
                    tx_excess_flag <= 1'b1;
                end
            end
        end
    end

    // counts published, done raised at end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_event <= 1'b0;
            rx_bytes_done <= `CNT_RST;
            tx_bytes_done <= `CNT_RST;
        end else begin
            done_event <= end_now;
            if (end_now) begin
                rx_bytes_done <= rx_cnt_reg;
                tx_bytes_done <= tx_cnt_reg;
            end
        end
    end

    // buffer access by the CPU is never gated here
    // configuration ports are used as held by the caller

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    miso_release_a: assert property (csn_s |=> !miso_oe)
        else $error("MISO driven while deselected");
    handback_noop_a: assert property (
        enable && handback_task && sem_owner == OWN_SLAVE && !end_now
        |=> sem_owner == OWN_SLAVE)
        else $error("handback moved slave ownership");
    enable_cpu_a: assert property (!enable
        |=> sem_owner == OWN_CPU && !acquired_event)
        else $error("disabled state not CPU owned");
    claim_held_a: assert property (
        enable && claim_task && sem_owner == OWN_CPU
        |=> acquired_event)
        else $error("claim while held not granted");
    race_cpu_a: assert property (
        enable && cs_fall && claim_task && sem_owner == OWN_FREE
        |=> sem_owner == OWN_CPU ##1 state_reg == X_IGNORE)
        else $error("race not awarded to CPU");
    end_release_a: assert property (end_now
        |=> done_event && sem_owner != OWN_SLAVE)
        else $error("end did not release");
    short_cpu_a: assert property (
        end_now && short_done_claim && enable
        |=> sem_owner == OWN_CPU && acquired_event)
        else $error("shortcut handover missing");
    overflow_drop_a: assert property (
        byte_done && granted && !rx_room
        |=> rx_overflow_flag && !rx_wr.en)
        else $error("overflow byte not dropped");
    ignore_drop_a: assert property (
        state_reg == X_IGNORE |=> !rx_wr.en)
        else $error("ignored data stored");
    dma_quiet_a: assert property (
        done_event |-> !$past(rx_wr.en))
        else $error("done during buffer write");

endmodule : serial_slave_unit

`default_nettype wire

/* verif/spi_master_model.sv */
`timescale 1ns/100ps
`default_nettype none

module spi_master_model (
    // Serial pins
    output logic csn_pin,
    output logic sck_pin,
    output logic mosi_pin,
    input wire logic miso
);
    logic [7:0] sent_q[$];
    logic [7:0] got_q[$];
    logic [7:0] tx_b;
    logic [7:0] rx_b;

    // Idle: deselected, clock parked
    initial begin
        csn_pin = 1'b1;
        sck_pin = 1'b0;
        mosi_pin = 1'b0;
    end

    // One frame of n bytes; sck rests at cpol between bits and outside it
    task automatic run(input logic cpol, input logic cpha, input logic lsbf,
                       input int n);
        sck_pin = cpol;
        #500 csn_pin = 1'b0;
        #1000;
        for (int b = 0; b < n; b++) begin
            tx_b = sent_q.pop_front();
            for (int i = 0; i < 8; i++) begin
                // shift on one edge, sample on the other
                if (cpha) sck_pin = ~cpol;
                // bit order from the format setting
                mosi_pin = lsbf ? tx_b[i] : tx_b[7-i];
                #62.5 sck_pin = cpha ? cpol : ~cpol;
                rx_b[lsbf ? i : 7-i] = miso;
                #62.5 if (!cpha) sck_pin = cpol;
            end
            got_q.push_back(rx_b);
        end
        #62.5 csn_pin = 1'b1;
        mosi_pin = ~mosi_pin; // Released line shows no stale value
        #1000;
    endtask : run
endmodule : spi_master_model

`default_nettype wire

/* verif/spi_slave_dma_semaphore_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "serial_slave_consts.svh"

module spi_slave_dma_semaphore_tb;
    import serial_slave_pkg::*;

    logic ref_clk = 1'b0, reset = 1'b1, enable = 1'b1, short_done_claim = 1'b0;
    logic claim_task = 1'b0, handback_task = 1'b0;
    spi_cfg_t cfg = '0;
    logic [7:0] tx_pad_char = 8'h00, ignored_fill_char = 8'h00;
    wire logic [7:0] tx_rd_data;
    logic [`CNT_W-1:0] rx_byte_limit = '0, tx_byte_limit = '0;
    logic [`ADDR_W-1:0] rx_buffer_pointer = '0, tx_buffer_pointer = '0;
    wire logic csn_pin, sck_pin, mosi_pin, miso_out, miso_oe, tx_rd_en, miso;
    wire logic acquired_event, done_event, rx_buffer_full_event;
    wire logic rx_overflow_flag, tx_excess_flag;
    wire logic [`ADDR_W-1:0] tx_rd_addr;
    wire logic [`CNT_W-1:0] rx_bytes_done, tx_bytes_done;
    dma_wr_t rx_wr;
    sem_owner_t sem_owner;
    int miscompares = 0, samples_checked = 0, acq_seen = 0, full_seen = 0;
    int full_exp = 0;
    logic [31:0] wr_q[$];
    logic [31:0] done_q[$];

    always #5 ref_clk = ~ref_clk;
    assign miso = miso_oe ? miso_out : 1'bz;

    serial_slave_unit i_serial_slave_unit (.ref_clk(ref_clk), .reset(reset),
        .enable(enable), .cfg(cfg), .tx_pad_char(tx_pad_char),
        .ignored_fill_char(ignored_fill_char), .rx_byte_limit(rx_byte_limit),
        .tx_byte_limit(tx_byte_limit), .rx_buffer_pointer(rx_buffer_pointer),
        .tx_buffer_pointer(tx_buffer_pointer),
        .short_done_claim(short_done_claim), .claim_task(claim_task),
        .handback_task(handback_task), .csn_pin(csn_pin), .sck_pin(sck_pin),
        .mosi_pin(mosi_pin), .miso_out(miso_out), .miso_oe(miso_oe),
        .rx_wr(rx_wr), .tx_rd_en(tx_rd_en), .tx_rd_addr(tx_rd_addr),
        .tx_rd_data(tx_rd_data), .acquired_event(acquired_event),
        .done_event(done_event), .rx_buffer_full_event(rx_buffer_full_event),
        .sem_owner(sem_owner), .rx_overflow_flag(rx_overflow_flag),
        .tx_excess_flag(tx_excess_flag), .rx_bytes_done(rx_bytes_done),
        .tx_bytes_done(tx_bytes_done));

    spi_master_model i_spi_master_model (.csn_pin(csn_pin), .sck_pin(sck_pin),
        .mosi_pin(mosi_pin), .miso(miso));

    // Buffer memory content derived from address
    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : mem

    // Read data stands while the strobe is high, garbage otherwise
    assign tx_rd_data = tx_rd_en ? mem(tx_rd_addr) : ~mem(tx_rd_addr);

    task automatic check(input string name, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Watcher pops expected writes and completions
    always @(posedge ref_clk) begin
        if (rx_wr.en === 1'b1)
            check("rx_wr", wr_q.size() ? wr_q.pop_front() : 32'hDEAD,
                  {8'h00, rx_wr.addr, rx_wr.data});
        if (done_event === 1'b1)
            check("done", done_q.size() ? done_q.pop_front() : 32'hDEAD,
                  {rx_bytes_done, tx_bytes_done, rx_overflow_flag,
                   tx_excess_flag});
        if (acquired_event === 1'b1) acq_seen++;
        if (rx_buffer_full_event === 1'b1) full_seen++;
    end

    task automatic fire(input bit hb);
        @(posedge ref_clk);
        if (hb) handback_task <= 1'b1;
        else claim_task <= 1'b1;
        @(posedge ref_clk);
        claim_task <= 1'b0;
        handback_task <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : fire

    // One frame with expectations noted before it starts
    task automatic frame(input logic [2:0] f, input int tl, rl, n, bit gr);
        logic [7:0] b;
        @(posedge ref_clk);
        cfg <= f;
        tx_byte_limit <= tl[`CNT_W-1:0];
        rx_byte_limit <= rl[`CNT_W-1:0];
        rx_buffer_pointer <= 16'($urandom);
        tx_buffer_pointer <= 16'($urandom);
        tx_pad_char <= 8'($urandom);
        ignored_fill_char <= 8'($urandom);
        @(posedge ref_clk);
        for (int k = 0; k < n; k++) begin
            b = 8'($urandom);
            i_spi_master_model.sent_q.push_back(b);
            if (gr && k < rl) wr_q.push_back({rx_buffer_pointer + k[15:0], b});
        end
        if (gr) done_q.push_back({(n < rl ? n[9:0] : rl[9:0]),
            (n < tl ? n[9:0] : tl[9:0]), n > rl, n > tl});
        if (gr && n >= rl) full_exp++;
        i_spi_master_model.run(f[2], f[1], f[0], n);
        for (int k = 0; k < n; k++)
            check("miso byte", !gr ? ignored_fill_char : k < tl ?
                mem(tx_buffer_pointer + k[15:0]) : tx_pad_char,
                i_spi_master_model.got_q.pop_front());
        check("miso released", 0, miso_oe);
        $display("test frame %b done", f);
    endtask : frame

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    initial begin
        #300000;
        miscompares++;
        conclude();
    end

    initial begin
        void'($urandom(32'hB33698DB));
        // no peer shares the slave here
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check("owner at enable", OWN_CPU, sem_owner);
        check("no initial acquire", 0, acq_seen);
        fire(1'b1);
        check("owner after handback", OWN_FREE, sem_owner);
        for (int m = 0; m < 4; m++) begin
            frame({m[1], m[0], m[1] ^ m[0]}, m % 3, 2, 3, 1);
            check("owner freed", OWN_FREE, sem_owner);
        end
        @(posedge ref_clk);
        short_done_claim <= 1'b1;
        fork
            frame(3'b101, 3, 3, 2, 1);
            begin #3000 fire(1'b0); end
        join
        check("one handover", 1, acq_seen);
        check("owner after shortcut", OWN_CPU, sem_owner);
        @(posedge ref_clk);
        short_done_claim <= 1'b0;
        frame(3'b010, 2, 2, 2, 0);
        fire(1'b0);
        check("claim while held", 2, acq_seen);
        fire(1'b1);
        fire(1'b1);
        check("stray handback", OWN_FREE, sem_owner);
        check("full events", full_exp, full_seen);
        check("pending notes", 0, wr_q.size() + done_q.size());
        $display("test semaphore done");
        @(posedge ref_clk);
        enable <= 1'b0;
        @(posedge ref_clk);
        enable <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("owner at re-enable", OWN_CPU, sem_owner);
        check("no acquire at re-enable", 2, acq_seen);
        $display("test enable done");
        conclude();
    end
endmodule : spi_slave_dma_semaphore_tb

`default_nettype wire
